/* File: design/hibpc_params.svh */
`ifndef HIBPC_PARAMS_SVH
`define HIBPC_PARAMS_SVH

// register byte offsets
`define HIBPC_OFS_COUNT 8'h00
`define HIBPC_OFS_MATCH 8'h04
`define HIBPC_OFS_LOAD 8'h0C
`define HIBPC_OFS_CTRL 8'h10
`define HIBPC_OFS_MASK 8'h14
`define HIBPC_OFS_RAW 8'h18
`define HIBPC_OFS_MIS 8'h1C
`define HIBPC_OFS_CLR 8'h20

// control register fields
`define HIBPC_CTL_CNT_EN 0
`define HIBPC_CTL_HIB_REQ 1
`define HIBPC_CTL_CLK_SEL 2
`define HIBPC_CTL_PIN_WEN 3
`define HIBPC_CTL_TIME_WEN 4
`define HIBPC_CTL_BAT_EN 5
`define HIBPC_CTL_CLK_EN 6
`define HIBPC_CTL_ABORT 7
`define HIBPC_CTL_WIDTH 8

// event bits
`define HIBPC_EV_MATCH 0
`define HIBPC_EV_BATLOW 2
`define HIBPC_EV_PIN 3
`define HIBPC_EV_WIDTH 4

// reset values
`define HIBPC_CTL_RESET 8'h00
`define HIBPC_EV_RESET 4'h0

// timing
`define HIBPC_XTAL_DIV 128
`define HIBPC_SYS_PERIOD_NS 50
`define HIBPC_REF_PERIOD_NS 30518
`define HIBPC_REF_TICK_CYC ((`HIBPC_REF_PERIOD_NS) / (`HIBPC_SYS_PERIOD_NS))
// write spacing: three reference ticks
`define HIBPC_WR_SPACING_NS (3 * `HIBPC_REF_PERIOD_NS)

`endif

/* File: design/hibpc_pkg.sv */
package hibpc_pkg;
  typedef enum logic [1:0] {
    HIBPC_AWAKE,
    HIBPC_SLEEP
  } hibpc_pwr_t;
endpackage

/* File: design/hibpc_top.sv */
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "hibpc_params.svh"
module hibpc_top
  import hibpc_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference clock pins; pin a is sampled for its rising edges, pin b is not sampled
  input wire logic clock_in_pin_a,
  input wire logic clock_in_pin_b,
  // wake pin, active low, and battery comparator (high below threshold)
  input wire logic rouse_n,
  input wire logic battery_below_threshold,
  // outputs
  output logic regulator_off_out,
  output logic clock_source_running,
  output logic irq
);

  localparam int TICK_CYC = `HIBPC_REF_TICK_CYC;
  localparam int SPACING_CYC = `HIBPC_WR_SPACING_NS / `HIBPC_SYS_PERIOD_NS;
  localparam int PRE_W = 7;
  localparam int SP_W = 12;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`HIBPC_CTL_WIDTH-1:0] hibernate_control_reg;
    logic [CNT_W-1:0] match_reg;
    logic [CNT_W-1:0] count_reg;
    logic [`HIBPC_EV_WIDTH-1:0] event_mask_reg;
    logic [`HIBPC_EV_WIDTH-1:0] raw_event_status_reg;
    logic [SP_W-1:0] spacing_cnt;
    logic [PRE_W-1:0] xtal_div;
    logic [1:0] pin_a_sync;
    logic pin_a_prev;
    logic [15:0] presc;
    hibpc_pwr_t pwr;
    logic reg_off;
    logic clk_run;
    logic irq;
  } hibpc_state_t;

  hibpc_state_t st_reg;
  hibpc_state_t st_next;

  // merge a byte-strobed write into an existing word
  function automatic logic [31:0] hibpc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // true for any mapped offset
  function automatic logic hibpc_mapped(input logic [7:0] a);
    return (a == `HIBPC_OFS_COUNT) || (a == `HIBPC_OFS_MATCH) ||
           (a == `HIBPC_OFS_LOAD) || (a == `HIBPC_OFS_CTRL) ||
           (a == `HIBPC_OFS_MASK) || (a == `HIBPC_OFS_RAW) ||
           (a == `HIBPC_OFS_MIS) || (a == `HIBPC_OFS_CLR);
  endfunction

  logic ref_tick;
  logic pin_rise;
  logic [31:0] wword;
  logic [`HIBPC_EV_WIDTH-1:0] ev_set;
  logic [`HIBPC_EV_WIDTH-1:0] ev_clr;
  logic [`HIBPC_CTL_WIDTH-1:0] ctl;

  always_comb begin
    st_next = st_reg;
    ctl = st_reg.hibernate_control_reg;
    ref_tick = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    wword = '0;
    pin_rise = 1'b0;

    // reference clock: pin a is sampled through a two-stage synchroniser
    st_next.pin_a_sync = {st_reg.pin_a_sync[0], clock_in_pin_a};
    st_next.pin_a_prev = st_reg.pin_a_sync[1];
    pin_rise = st_reg.pin_a_sync[1] & ~st_reg.pin_a_prev;
    // pin b only drives the crystal amplifier; nothing to sample here
    st_next.clk_run = ctl[`HIBPC_CTL_CLK_EN];
    if (!ctl[`HIBPC_CTL_CLK_EN]) begin
      st_next.xtal_div = '0;
    end else if (ctl[`HIBPC_CTL_CLK_SEL]) begin
      ref_tick = pin_rise;
    end else if (pin_rise) begin
      st_next.xtal_div = st_reg.xtal_div + 7'h01;
      ref_tick = (st_reg.xtal_div == PRE_W'(`HIBPC_XTAL_DIV - 1));
    end

    // once-per-second counter from the reference
    if (ref_tick && ctl[`HIBPC_CTL_CNT_EN]) begin
      if (st_reg.presc == 16'h7FFF) begin
        st_next.presc = '0;
        st_next.count_reg = st_reg.count_reg + CNT_W'(1);
        if (st_reg.count_reg + CNT_W'(1) == st_reg.match_reg) begin
          ev_set[`HIBPC_EV_MATCH] = 1'b1;
        end
      end else begin
        st_next.presc = st_reg.presc + 16'h0001;
      end
    end

    // low-battery sensing is frozen while asleep
    if (ctl[`HIBPC_CTL_BAT_EN] && st_reg.pwr == HIBPC_AWAKE &&
        battery_below_threshold) begin
      ev_set[`HIBPC_EV_BATLOW] = 1'b1;
    end
    if (!rouse_n) begin
      ev_set[`HIBPC_EV_PIN] = 1'b1;
    end

    // write spacing window counts down; writes are applied at once
    if (st_reg.spacing_cnt != '0) begin
      st_next.spacing_cnt = st_reg.spacing_cnt - SP_W'(1);
    end

    // axi write: collect address and data in either order
    if (s_axi_awvalid && !st_reg.aw_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_reg.w_held && !st_reg.bvalid) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = hibpc_mapped(st_reg.aw_addr) ? 2'h0 : 2'h2;
      st_next.spacing_cnt = SP_W'(SPACING_CYC);
      case (st_reg.aw_addr)
        `HIBPC_OFS_MATCH: begin
          st_next.match_reg = hibpc_merge(st_reg.match_reg, st_reg.w_data, st_reg.w_strb);
        end
        `HIBPC_OFS_LOAD: begin
          st_next.count_reg = hibpc_merge(st_reg.count_reg, st_reg.w_data, st_reg.w_strb);
          st_next.presc = '0;
        end
        `HIBPC_OFS_CTRL: begin
          wword = hibpc_merge({24'h000000, ctl}, st_reg.w_data, st_reg.w_strb);
          st_next.hibernate_control_reg = wword[`HIBPC_CTL_WIDTH-1:0];
        end
        `HIBPC_OFS_MASK: begin
          wword = hibpc_merge({28'h0000000, st_reg.event_mask_reg}, st_reg.w_data,
                              st_reg.w_strb);
          st_next.event_mask_reg = wword[`HIBPC_EV_WIDTH-1:0];
        end
        `HIBPC_OFS_CLR: begin
          if (st_reg.w_strb[0]) begin
            ev_clr = st_reg.w_data[`HIBPC_EV_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // set beats clear in the same cycle
    st_next.raw_event_status_reg = (st_reg.raw_event_status_reg & ~ev_clr) | ev_set;

    // power sequencing
    case (st_reg.pwr)
      HIBPC_AWAKE: begin
        st_next.reg_off = 1'b0;
        if (st_next.hibernate_control_reg[`HIBPC_CTL_HIB_REQ]) begin
          st_next.hibernate_control_reg[`HIBPC_CTL_HIB_REQ] = 1'b0;
          // the abort bit may arrive in the same write as the request
          if (!(st_next.hibernate_control_reg[`HIBPC_CTL_ABORT] &&
                st_reg.raw_event_status_reg[`HIBPC_EV_BATLOW])) begin
            st_next.pwr = HIBPC_SLEEP;
            st_next.reg_off = 1'b1;
          end
        end
      end
      HIBPC_SLEEP: begin
        if ((ctl[`HIBPC_CTL_PIN_WEN] && !rouse_n) ||
            (ctl[`HIBPC_CTL_TIME_WEN] && ev_set[`HIBPC_EV_MATCH])) begin
          st_next.pwr = HIBPC_AWAKE;
          st_next.reg_off = 1'b0;
        end
      end
      default: begin
        st_next.pwr = HIBPC_AWAKE;
        st_next.reg_off = 1'b0;
      end
    endcase

    // axi read: reads never wait on the spacing window
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = hibpc_mapped(s_axi_araddr[7:0]) ? 2'h0 : 2'h2;
      case (s_axi_araddr[7:0])
        `HIBPC_OFS_COUNT: st_next.rdata = 32'(st_reg.count_reg);
        `HIBPC_OFS_MATCH: st_next.rdata = 32'(st_reg.match_reg);
        `HIBPC_OFS_CTRL: st_next.rdata = {24'h000000, ctl};
        `HIBPC_OFS_MASK: st_next.rdata = {28'h0000000, st_reg.event_mask_reg};
        `HIBPC_OFS_RAW: st_next.rdata = {28'h0000000, st_reg.raw_event_status_reg};
        `HIBPC_OFS_MIS: begin
          st_next.rdata = {28'h0000000,
                           st_reg.raw_event_status_reg & st_reg.event_mask_reg};
        end
        default: st_next.rdata = 32'h00000000;
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    st_next.irq = |(st_next.raw_event_status_reg & st_next.event_mask_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.hibernate_control_reg <= `HIBPC_CTL_RESET;
      st_reg.raw_event_status_reg <= `HIBPC_EV_RESET;
      st_reg.pwr <= HIBPC_AWAKE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.aw_held ? 1'b0 : ~st_reg.bvalid;
  assign s_axi_wready = st_reg.w_held ? 1'b0 : ~st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign regulator_off_out = st_reg.reg_off;
  assign clock_source_running = st_reg.clk_run;
  assign irq = st_reg.irq;

endmodule

/* File: tb/hibpc_vreg_model.sv */
`timescale 1ns/100ps
// ==========
// external regulator: output collapses at once, ramps back over RAMP+1 cycles
module hibpc_vreg_model #(
  parameter int RAMP = 4
) (
  // control
  input wire logic clk_sys,
  input wire logic regulator_off_out,
  // supply status
  output logic power_ok
);
  int ramp_cnt = 0;
  initial power_ok = 1'b0;
  always @(posedge clk_sys) begin
    if (regulator_off_out) begin
      ramp_cnt <= 0;
      power_ok <= 1'b0;
    end else if (ramp_cnt < RAMP) begin
      ramp_cnt <= ramp_cnt + 1;
    end else begin
      power_ok <= 1'b1;
    end
  end
endmodule

/* File: tb/hibpc_top_props.sv */
`timescale 1ns/100ps
module hibpc_top_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // outputs
  input wire logic regulator_off_out,
  input wire logic clock_source_running,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========
  // reset and handshakes
  AST_RST_OUT: assert property (disable iff (1'b0) reset |=>
    !regulator_off_out && !irq && !clock_source_running) else $error("outputs set after reset");
  AST_RDY: assert property ($fell(reset) |->
    s_axi_awready && s_axi_wready && s_axi_arready) else $error("not ready after reset");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0) else $error("refused read carries data");
  // ==========
  // regulator-off and clock-running rises follow control writes
  AST_OFF_ON_WRITE: assert property ($rose(regulator_off_out) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("regulator off without write");
  AST_CLK_ON_WRITE: assert property ($rose(clock_source_running) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("clock started without write");
  C_OFF: cover property ($rose(regulator_off_out));
  C_WAKE: cover property ($fell(regulator_off_out));
  C_IRQ: cover property ($rose(irq));
endmodule
bind hibpc_top hibpc_top_props u_props (
  .clk_sys(clk_sys), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .regulator_off_out(regulator_off_out),
  .clock_source_running(clock_source_running), .irq(irq)
);

/* File: tb/hibpc_tb_top.sv */
`timescale 1ns/100ps
`include "hibpc_params.svh"
module hibpc_tb_top
  import hibpc_pkg::*;
;
  localparam int SP = 4 * `HIBPC_REF_TICK_CYC;
  logic clk_sys = 0, reset = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, lfsr = 32'hA13940BD;
  logic pa = 0, pb = 0, rouse_n = 1, bat = 0;
  logic awr, wr_rdy, bvalid, arr, rvalid, reg_off, clk_run, irq, power_ok;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q[$];
  int n_errors = 0, n_compared = 0;
  hibpc_top DUT (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .clock_in_pin_a(pa), .clock_in_pin_b(pb), .rouse_n(rouse_n),
    .battery_below_threshold(bat), .regulator_off_out(reg_off),
    .clock_source_running(clk_run), .irq(irq));
  hibpc_vreg_model u_vreg (.clk_sys(clk_sys), .regulator_off_out(reg_off), .power_ok(power_ok));
  initial forever #25 clk_sys = ~clk_sys;
  // reference source always supplied, oscillator-like rate
  initial forever begin
    repeat (305) @(posedge clk_sys);
    pa <= ~pa;
  end
  function automatic logic [31:0] lfsr_step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && rready) chk("read", exp_q.pop_front(), {rresp, rdata});
  end
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int t;
    @(posedge clk_sys);
    awaddr <= {24'h0, a};
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 64 && bvalid !== 1'b1; t++) begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 34'h0, 34'(bresp));
    repeat (SP) @(posedge clk_sys);
  endtask
  task automatic rd(logic [7:0] a, logic [33:0] e);
    int t;
    @(posedge clk_sys);
    exp_q.push_back(e);
    araddr <= {24'h0, a};
    arv <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 64 && rvalid !== 1'b1; t++) begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(`HIBPC_OFS_CTRL, 34'h0);
    rd(8'h40, {2'h2, 32'h0});
    lfsr = lfsr_step(lfsr) | 32'h100;
    wr(`HIBPC_OFS_MATCH, lfsr);
    rd(`HIBPC_OFS_MATCH, {2'h0, lfsr});
    for (int i = 0; i < 2; i++) begin
      // the spacing wait inside wr also covers crystal settling
      wr(`HIBPC_OFS_CTRL, i ? 32'h44 : 32'h40);
      rd(`HIBPC_OFS_CTRL, i ? 34'h44 : 34'h40);
      chk("clk_run", 34'h1, 34'(clk_run));
    end
    bat <= 1'b1;
    wr(`HIBPC_OFS_CTRL, 32'h64);
    rd(`HIBPC_OFS_RAW, 34'h4);
    wr(`HIBPC_OFS_MASK, 32'h4);
    chk("irq", 34'h1, 34'(irq));
    rd(`HIBPC_OFS_MIS, 34'h4);
    wr(`HIBPC_OFS_CTRL, 32'hE6);
    chk("abort", 34'h0, {33'h0, reg_off | ~power_ok});
    bat <= 1'b0;
    wr(`HIBPC_OFS_CLR, 32'h4);
    chk("irq_clr", 34'h0, 34'(irq));
    wr(`HIBPC_OFS_CTRL, 32'h44);
    bat <= 1'b1;
    rd(`HIBPC_OFS_RAW, 34'h0);
    bat <= 1'b0;
    wr(`HIBPC_OFS_CTRL, 32'h6E);
    chk("off", 34'h1, {33'h0, reg_off & ~power_ok});
    bat <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(`HIBPC_OFS_RAW, 34'h0);
    bat <= 1'b0;
    rouse_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("pin_wake", 34'h0, 34'(reg_off));
    wr(`HIBPC_OFS_CTRL, 32'h52);
    repeat (8) @(posedge clk_sys);
    chk("no_pin_wake", 34'h1, 34'(reg_off));
    rouse_n <= 1'b1;
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("reset_off", 34'h0, 34'(reg_off));
    repeat (4) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
